// File: testbench/peao_pad_partner.sv
/*
  Pad-side partner: resolves every pad level from the block's drive, an outside driver and the pull-up.
  Assumes the bench chooses the outside drivers; a pin nobody holds floats.
*/
`timescale 1ns/1ps
module peao_pad_partner (
  // Clock.
  input  wire logic        clk,
  // Block pad controls.
  input  wire logic [20:0] pad_out,
  input  wire logic [20:0] pad_oe,
  input  wire logic [20:0] pad_pullup,
  // Outside drivers.
  input  wire logic [20:0] ext_en,
  input  wire logic [20:0] ext_val,
  // Resolved levels.
  output logic      [20:0] pad_level
);
  logic [20:0] float_r = 21'h0AAAAA;

  // A floating pin flips every cycle, so a stale level can never pass for a real one.
  always @(posedge clk) begin
    float_r <= ~float_r;
  end

  // The block's drive wins, then the outside driver, then the pull-up.
  assign pad_level = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val) |
                     (~pad_oe & ~ext_en & (pad_pullup | float_r));
endmodule : peao_pad_partner

// File: testbench/peao_properties.sv
/*
  Concurrent checks on the pad override block, from its ports only.
  Assumes a bind into peao_top, one clock and an active-low reset.
*/
`timescale 1ns/1ps
module peao_properties (
  // Clock, reset and bus.
  input wire logic        CLK_SYS, RESETN, PSEL, PENABLE, PREADY, PSLVERR,
  input wire logic [7:0]  PADDR,
  // Modes and peripherals.
  input wire logic        PROG_MODE, PROG_DATA_OUT, SERIAL0_RX_ENABLE, SERIAL0_TX_ENABLE, SERIAL0_TX_DATA,
  input wire logic        SERIAL0_SYNC_SELECT, SERIAL0_CLOCK_OUT, SERIAL0_RX_DATA, LEGACY_MODE,
  input wire logic        TIMER3_COMPARE_A_EN, TIMER3_COMPARE_B_EN, TIMER3_COMPARE_C_EN,
  input wire logic        TIMER3_COMPARE_A_OUT, TIMER3_COMPARE_B_OUT, TIMER3_COMPARE_C_OUT,
  input wire logic        TEST_PORT_ENABLE, TAP_SHIFT_INSTR, TAP_SHIFT_DATA, TAP_TDO_DATA, TAP_TCK, TAP_TDI, TAP_TMS,
  input wire logic        TIMER0_ASYNC_SELECT, EXT_MEMORY_ENABLE,
  input wire logic        XMEM_ADDR_LATCH, XMEM_READ_STROBE, XMEM_WRITE_STROBE,
  // Pads.
  input wire logic [20:0] PAD_IN, PAD_OUT, PAD_OE, PAD_PULLUP, PAD_IN_EN
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RESETN);

  // Pad samples reach the peripherals over fixed synchroniser paths.
  sequence s_rx_seen;
    ##3 (SERIAL0_RX_DATA == $past(PAD_IN[0], 3));
  endsequence
  sequence s_tck_seen;
    ##2 (TAP_TCK == ($past(PAD_IN[12], 2) && TEST_PORT_ENABLE) &&
      TAP_TMS == ($past(PAD_IN[13], 2) && TEST_PORT_ENABLE) && TAP_TDI == ($past(PAD_IN[15], 2) && TEST_PORT_ENABLE));
  endsequence

  property p_rx_path;
    1'b1 |-> s_rx_seen;
  endproperty
  a_rx_path: assert property (p_rx_path) else $error("receive data does not follow its pad");
  property p_rx_input;
    SERIAL0_RX_ENABLE |-> !PAD_OE[0];
  endproperty
  a_rx_input: assert property (p_rx_input) else $error("receive pin driven");
  property p_tap_clock;
    1'b1 |-> s_tck_seen;
  endproperty
  a_tap_clock: assert property (p_tap_clock) else $error("test input path wrong");
  property p_tx_force;
    SERIAL0_TX_ENABLE && !PROG_MODE |-> PAD_OE[1] && !PAD_PULLUP[1] && PAD_OUT[1] == SERIAL0_TX_DATA;
  endproperty
  a_tx_force: assert property (p_tx_force) else $error("transmit pin not forced");
  property p_prog_lines;
    PROG_MODE |-> PAD_OE[1] && !PAD_OE[0] && PAD_OUT[1] == PROG_DATA_OUT;
  endproperty
  a_prog_lines: assert property (p_prog_lines) else $error("programming lines wrong");
  property p_sync_clock;
    SERIAL0_SYNC_SELECT |-> PAD_OUT[2] == SERIAL0_CLOCK_OUT;
  endproperty
  a_sync_clock: assert property (p_sync_clock) else $error("sync clock not on pin");
  property p_compare_cb;
    (!TIMER3_COMPARE_C_EN || PAD_OUT[5] == TIMER3_COMPARE_C_OUT) &&
    (!TIMER3_COMPARE_B_EN || PAD_OUT[4] == TIMER3_COMPARE_B_OUT);
  endproperty
  a_compare_cb: assert property (p_compare_cb) else $error("compare C or B not on pin");
  property p_compare_a;
    TIMER3_COMPARE_A_EN |-> PAD_OUT[3] == TIMER3_COMPARE_A_OUT;
  endproperty
  a_compare_a: assert property (p_compare_a) else $error("compare A not on pin");
  property p_tap_pins;
    TEST_PORT_ENABLE |-> PAD_IN_EN[15:12] == 4'h0 && PAD_PULLUP[15:12] == 4'hB && (PAD_OE[15:12] & 4'hB) == 4'h0;
  endproperty
  a_tap_pins: assert property (p_tap_pins) else $error("test port pins not claimed");
  property p_tdo;
    TEST_PORT_ENABLE |-> PAD_OE[14] == (TAP_SHIFT_INSTR || TAP_SHIFT_DATA) && PAD_OUT[14] == TAP_TDO_DATA;
  endproperty
  a_tdo: assert property (p_tdo) else $error("test data out drive wrong");
  property p_legacy_f;
    LEGACY_MODE |-> (PAD_OE[15:8] & 8'hBF) == 8'h00;
  endproperty
  a_legacy_f: assert property (p_legacy_f) else $error("port F drives in legacy mode");
  property p_osc;
    TIMER0_ASYNC_SELECT |-> (PAD_OE[20:19] | PAD_PULLUP[20:19] | PAD_IN_EN[20:19]) == 2'h0;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator pins not released");
  property p_xmem;
    EXT_MEMORY_ENABLE |-> PAD_OE[18:16] == 3'h7 && PAD_PULLUP[18:16] == 3'h0 &&
      PAD_OUT[18:16] == {XMEM_ADDR_LATCH, XMEM_READ_STROBE, XMEM_WRITE_STROBE};
  endproperty
  a_xmem: assert property (p_xmem) else $error("memory strobes not on pins");
  property p_bus_answer;
    PSEL |-> PREADY && PSLVERR == (PENABLE && (PADDR > 8'h24 || PADDR[1:0] != 2'h0));
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer wrong");
endmodule : peao_properties

bind peao_top peao_properties u_props (.*);

// File: testbench/port_efg_alternate_override_bench.sv
/*
  Random self-checking bench for the port E, F and G override block.
  Assumes the pad partner model and the bound property checker.
*/
`timescale 1ns/1ps
module port_efg_alternate_override_bench;
  import peao_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, st = 32'h0, seed = 32'hCE91FDC6, prdata, rd, wd, pins;
  logic        pready, pslverr, err, rx_data, clk_in, prog_data_in, cap, t3c;
  logic [3:0]  ei;
  logic [20:0] ext_en = 21'h0, ext_val = 21'h0, pad_in, pad_out, pad_oe, pad_pu, pad_ie;
  logic [20:0] x_out, x_oe, x_pu, x_ie, lvl, known;
  logic [7:0]  regs [0:6];
  int          fail_count = 0, compares = 0, cycles = 0, k;

  peao_top u_dut (
    .CLK_SYS(clk), .RESETN(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .LEGACY_MODE(st[0]), .PROG_MODE(st[1]), .SERIAL0_RX_ENABLE(st[2]), .SERIAL0_TX_ENABLE(st[3]),
    .SERIAL0_SYNC_SELECT(st[4]), .SERIAL0_TX_DATA(st[5]), .SERIAL0_CLOCK_OUT(st[6]),
    .SERIAL0_RX_DATA(rx_data), .SERIAL0_CLOCK_IN(clk_in), .PROG_DATA_OUT(st[7]), .PROG_DATA_IN(prog_data_in),
    .TIMER3_COMPARE_A_EN(st[8]), .TIMER3_COMPARE_B_EN(st[9]), .TIMER3_COMPARE_C_EN(st[10]),
    .TIMER3_COMPARE_A_OUT(st[11]), .TIMER3_COMPARE_B_OUT(st[12]), .TIMER3_COMPARE_C_OUT(st[13]),
    .TIMER3_CAPTURE_IN(cap), .TIMER3_EXT_CLOCK_IN(t3c), .EXT_INT_ENABLE(st[17:14]), .EXT_INT_IN(ei),
    .TEST_PORT_ENABLE(st[18]), .TAP_SHIFT_INSTR(st[19]), .TAP_SHIFT_DATA(st[20]), .TAP_TDO_DATA(st[21]),
    .TAP_TDI(), .TAP_TMS(), .TAP_TCK(), .TIMER0_ASYNC_SELECT(st[22]), .EXT_MEMORY_ENABLE(st[23]),
    .XMEM_ADDR_LATCH(st[26]), .XMEM_READ_STROBE(st[25]), .XMEM_WRITE_STROBE(st[24]), .PAD_IN(pad_in),
    .PAD_OUT(pad_out), .PAD_OE(pad_oe), .PAD_PULLUP(pad_pu), .PAD_IN_EN(pad_ie)
  );
  peao_pad_partner u_pads (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pu),
    .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_in));

  // Clock at 40 MHz.
  always #12.5 clk = ~clk;

  // Ends a hung run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // One bus transfer from just after an edge, then an idle cycle.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16) begin
      n++;
      @(posedge clk);
    end
    chk(n < 16, "no bus answer");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  // Expected pad controls and levels.
  function automatic void model();
    logic [20:0] o, d;
    o = {regs[4][4:0], regs[2], regs[0]};
    d = {regs[5][4:0], regs[3], regs[1]};
    x_out = o;
    x_oe = d;
    x_ie = '1;
    x_pu = o & ~d & {21{~regs[6][0]}};
    if (st[2]) begin
      x_oe[0] = 1'b0;
      x_pu[0] = o[0] & ~regs[6][0];
    end
    if (st[3]) begin
      x_oe[1] = 1'b1;
      x_out[1] = st[5];
      x_pu[1] = 1'b0;
    end
    if (st[1]) begin
      x_oe[1:0] = 2'h2;
      x_out[1] = st[7];
      x_pu[1] = 1'b0;
    end
    x_out[5:2] = {st[10] ? st[13] : o[5], st[9] ? st[12] : o[4], st[8] ? st[11] : o[3], st[4] ? st[6] : o[2]};
    if (st[0]) begin
      x_oe[20:8] = 13'h0;
      x_pu[20:16] = 5'h0;
      x_out[20:16] = 5'h0;
    end
    if (st[18]) begin
      x_pu[15:12] = 4'hB;
      x_oe[15:12] = {1'b0, st[19] | st[20], 2'h0};
      x_out[14] = st[21];
      x_ie[15:12] = 4'h0;
    end
    if (st[22]) begin
      x_pu[20:19] = 2'h0;
      x_oe[20:19] = 2'h0;
      x_ie[20:19] = 2'h0;
    end
    if (st[23]) begin
      x_oe[18:16] = 3'h7;
      x_pu[18:16] = 3'h0;
      x_out[18:16] = st[26:24];
    end
    known = x_oe | ext_en | x_pu | ~x_ie;
    lvl = (x_oe & x_out) | (~x_oe & ext_en & ext_val) | (~x_oe & ~ext_en & x_pu);
  endfunction : model

  // Reset with the test port on, reset values, unmapped access.
  task automatic reset_phase();
    st <= 32'h0004_0000;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(pad_pu[15:12] === 4'hB && pad_ie[15:12] === 4'h0, "test pins in reset");
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      regs[i] = 8'h00;
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd === 32'h0 && err === 1'b0, "register reset value");
    end
    apb(1'b0, 8'h28, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped read not refused");
  endtask : reset_phase

  // Random peripheral levels, outside drivers and register writes.
  task automatic run(input int n);
    repeat (n) begin
      st <= rnd();
      ext_en <= 21'(rnd());
      ext_val <= 21'(rnd());
      k = int'(rnd() % 7);
      wd = rnd();
      apb(1'b1, 8'(k * 4), wd);
      regs[k] = wd[7:0] & (k == 6 ? 8'h01 : k > 3 ? 8'h1F : 8'hFF);
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(rd === {24'h0, regs[k]} && err === 1'b0, "register read-back");
      repeat (4) @(posedge clk);
      @(negedge clk);
      model();
      chk(pad_out === x_out, "pad value");
      chk(pad_oe === x_oe, "pad direction");
      chk(pad_pu === x_pu, "pad pull-up");
      chk(pad_ie === x_ie, "pad input enable");
      chk(((({cap, t3c, ei, rx_data, prog_data_in, clk_in} ^ {lvl[7:6], lvl[7:4], lvl[0], lvl[0],
        lvl[2] & st[4] & ~regs[1][2]}) & {known[7:6], known[7:4], known[0], known[0], known[2]}) === 9'h0),
        "peripheral inputs");
      @(posedge clk);
      apb(1'b0, OFS_PIN_E, 32'h0);
      pins[7:0] = rd[7:0];
      apb(1'b0, OFS_PIN_F, 32'h0);
      pins[15:8] = rd[7:0];
      apb(1'b0, OFS_PIN_G, 32'h0);
      pins[20:16] = rd[4:0];
      chk((((pins[20:0] ^ (lvl & x_ie)) & known) === 21'h0), "pin read-back");
    end
  endtask : run

  // No conversion runs here, so port F outputs may switch at will.
  initial begin
    reset_phase();
    run(90);
    reset_phase();
    run(40);
    tally_and_finish();
  end
endmodule : port_efg_alternate_override_bench

// File: verilog/peao_pin_cell.sv
/*
  One pad's override cell: port register defaults merged with override enables and values.
  Assumes the parent computes the overrides on the system clock.
*/
`timescale 1ns/1ps
module peao_pin_cell (
  // Port register defaults.
  input  wire logic port_out,
  input  wire logic port_dir,
  input  wire logic global_pullup_disable,
  // Override enables and values.
  input  wire logic pullup_override_en,
  input  wire logic pullup_override_val,
  input  wire logic direction_override_en,
  input  wire logic direction_override_val,
  input  wire logic port_value_override_en,
  input  wire logic port_value_override_val,
  input  wire logic input_enable_override_en,
  input  wire logic input_enable_override_val,
  // Pad controls.
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pullup,
  output logic      pad_in_en
);

  // Each control takes its override value when enabled, else the port default.
  always_comb begin
    pad_pullup = pullup_override_en ? pullup_override_val
                                    : (port_out & ~port_dir & ~global_pullup_disable);
    pad_oe     = direction_override_en ? direction_override_val : port_dir;
    pad_out    = port_value_override_en ? port_value_override_val : port_out;
    pad_in_en  = input_enable_override_en ? input_enable_override_val : 1'b1;
  end

endmodule : peao_pin_cell

// File: verilog/peao_pkg.sv
/*
  Constants of the port E, F and G override block: pad layout, offsets, fields, resets.
  Assumes a 32-bit APB with byte addresses and one aligned word per register.
*/
package peao_pkg;

  // Pad vector layout: port E, then port F, then port G.
  localparam int unsigned PIN_COUNT   = 21;
  localparam int unsigned PORT_E_BASE = 0;
  localparam int unsigned PORT_F_BASE = 8;
  localparam int unsigned PORT_G_BASE = 16;
  localparam int unsigned PORT_WIDTH  = 8;
  localparam int unsigned PORT_G_WIDTH = 5;

  // Register byte offsets.
  localparam logic [7:0] OFS_PORT_E_OUT = 8'h00;
  localparam logic [7:0] OFS_PORT_E_DIR = 8'h04;
  localparam logic [7:0] OFS_PORT_F_OUT = 8'h08;
  localparam logic [7:0] OFS_PORT_F_DIR = 8'h0C;
  localparam logic [7:0] OFS_PORT_G_OUT = 8'h10;
  localparam logic [7:0] OFS_PORT_G_DIR = 8'h14;
  localparam logic [7:0] OFS_CTRL       = 8'h18;
  localparam logic [7:0] OFS_PIN_E      = 8'h1C;
  localparam logic [7:0] OFS_PIN_F      = 8'h20;
  localparam logic [7:0] OFS_PIN_G      = 8'h24;

  // Control register field positions.
  localparam int unsigned CTRL_PULLUP_DISABLE_BIT = 0;

  // Reset values.
  localparam logic [7:0]  PORT_RESET = 8'h00;
  localparam logic [4:0]  PORT_G_RESET = 5'h00;
  localparam logic [0:0]  CTRL_RESET = 1'h0;
  localparam logic [20:0] PIN_RESET  = 21'h000000;

  // Pin positions inside ports E, F and G.
  localparam int unsigned PE_RX       = 0;
  localparam int unsigned PE_TX       = 1;
  localparam int unsigned PE_XCLK     = 2;
  localparam int unsigned PE_CMP_A    = 3;
  localparam int unsigned PE_CMP_B    = 4;
  localparam int unsigned PE_CMP_C    = 5;
  localparam int unsigned PE_T3_CLK   = 6;
  localparam int unsigned PE_CAPTURE  = 7;
  localparam int unsigned PE_INT_BASE = 4;
  localparam int unsigned PF_TCK      = 4;
  localparam int unsigned PF_TMS      = 5;
  localparam int unsigned PF_TDO      = 6;
  localparam int unsigned PF_TDI      = 7;
  localparam int unsigned PG_WSTROBE  = 0;
  localparam int unsigned PG_RSTROBE  = 1;
  localparam int unsigned PG_LATCH    = 2;
  localparam int unsigned PG_OSC_OUT  = 3;
  localparam int unsigned PG_OSC_IN   = 4;

endpackage : peao_pkg

// File: verilog/peao_top.sv
/*
  Port E, F and G alternate-function override with APB port, direction, control and pin registers.
  Assumes peripherals drive their enables and data on CLK_SYS, and pads are asynchronous.
*/
// The implementer's own choices: the address map and register access over APB.
// Notes on behaviour
// - Clock pin direction follows its direction bit.
// - Sync select gates clock value override.
// - Receiver enabled forces receive pin input.
// - Receive pull-up from port bit, unless disabled.
// - Transmitter forces output, data, pull-up off.
// - Compare C and B drive E5, E4.
// - Interrupt enables force E7..E4 inputs on.
// - Programming mode uses E1 out, E0 in.
// - Test port pull-ups hold through reset.
// - Test port takes F7..F4, inputs off.
// - TDO driven only in shift states.
// - TDO tri-stated outside shift states.
// - Port F3..F0 carry no override but the legacy direction.
// - Legacy mode makes port F input only, except TDO (F6) with the test port on.
// - Legacy mode gives port G to alternates.
// - Async timer frees G4, G3 for oscillator.
// - External memory drives G2, G1 strobes.
// - External memory drives G0 write strobe.
`timescale 1ns/1ps
module peao_top
  import peao_pkg::*;
(
  // Clock and reset.
  input  wire logic        CLK_SYS,
  input  wire logic        RESETN,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Mode straps.
  input  wire logic        LEGACY_MODE,
  input  wire logic        PROG_MODE,
  // Serial transceiver 0.
  input  wire logic        SERIAL0_RX_ENABLE,
  input  wire logic        SERIAL0_TX_ENABLE,
  input  wire logic        SERIAL0_SYNC_SELECT,
  input  wire logic        SERIAL0_TX_DATA,
  input  wire logic        SERIAL0_CLOCK_OUT,
  output logic             SERIAL0_RX_DATA,
  output logic             SERIAL0_CLOCK_IN,
  // Serial programming.
  input  wire logic        PROG_DATA_OUT,
  output logic             PROG_DATA_IN,
  // Timer 3.
  input  wire logic        TIMER3_COMPARE_A_EN,
  input  wire logic        TIMER3_COMPARE_B_EN,
  input  wire logic        TIMER3_COMPARE_C_EN,
  input  wire logic        TIMER3_COMPARE_A_OUT,
  input  wire logic        TIMER3_COMPARE_B_OUT,
  input  wire logic        TIMER3_COMPARE_C_OUT,
  output logic             TIMER3_CAPTURE_IN,
  output logic             TIMER3_EXT_CLOCK_IN,
  // External interrupts 7..4.
  input  wire logic [3:0]  EXT_INT_ENABLE,
  output logic      [3:0]  EXT_INT_IN,
  // Test port.
  input  wire logic        TEST_PORT_ENABLE,
  input  wire logic        TAP_SHIFT_INSTR,
  input  wire logic        TAP_SHIFT_DATA,
  input  wire logic        TAP_TDO_DATA,
  output logic             TAP_TDI,
  output logic             TAP_TMS,
  output logic             TAP_TCK,
  // Timer 0 and external memory.
  input  wire logic        TIMER0_ASYNC_SELECT,
  input  wire logic        EXT_MEMORY_ENABLE,
  input  wire logic        XMEM_ADDR_LATCH,
  input  wire logic        XMEM_READ_STROBE,
  input  wire logic        XMEM_WRITE_STROBE,
  // Pads: port E in 7..0, port F in 15..8, port G in 20..16.
  input  wire logic [20:0] PAD_IN,
  output logic      [20:0] PAD_OUT,
  output logic      [20:0] PAD_OE,
  output logic      [20:0] PAD_PULLUP,
  output logic      [20:0] PAD_IN_EN
);

  // Register state.
  logic [7:0]  port_e_out_r, port_e_out_nxt;
  logic [7:0]  port_e_dir_r, port_e_dir_nxt;
  logic [7:0]  port_f_out_r, port_f_out_nxt;
  logic [7:0]  port_f_dir_r, port_f_dir_nxt;
  logic [4:0]  port_g_out_r, port_g_out_nxt;
  logic [4:0]  port_g_dir_r, port_g_dir_nxt;
  logic [0:0]  ctrl_r,       ctrl_nxt;
  logic [31:0] rdata_r,      rdata_nxt;
  // Pad sampling state.
  logic [20:0] pad_s1_r, pad_s2_r;
  logic [20:0] pin_state_r, pin_state_nxt;
  // Flat port defaults and override vectors.
  logic [20:0] port_out_all, port_dir_all;
  logic [20:0] pu_oe, pu_ov, dd_oe, dd_ov, pv_oe, pv_ov, die_oe, die_ov;
  logic        global_pullup_disable;
  logic        apb_write, apb_setup, addr_hit;

  assign global_pullup_disable = ctrl_r[CTRL_PULLUP_DISABLE_BIT];
  assign port_out_all = {port_g_out_r, port_f_out_r, port_e_out_r};
  assign port_dir_all = {port_g_dir_r, port_f_dir_r, port_e_dir_r};

  // Override matrix; later assignments win.
  always_comb begin
    pu_oe  = '0;
    pu_ov  = '0;
    dd_oe  = '0;
    dd_ov  = '0;
    pv_oe  = '0;
    pv_ov  = '0;
    die_oe = '0;
    die_ov = '0;
    if (SERIAL0_RX_ENABLE) begin
      dd_oe[PE_RX] = 1'b1;
      dd_ov[PE_RX] = 1'b0;
      pu_oe[PE_RX] = 1'b1;
      pu_ov[PE_RX] = port_e_out_r[PE_RX] & ~global_pullup_disable;
    end
    if (SERIAL0_TX_ENABLE) begin
      pu_oe[PE_TX] = 1'b1;
      pu_ov[PE_TX] = 1'b0;
      dd_oe[PE_TX] = 1'b1;
      dd_ov[PE_TX] = 1'b1;
      pv_oe[PE_TX] = 1'b1;
      pv_ov[PE_TX] = SERIAL0_TX_DATA;
    end
    if (PROG_MODE) begin
      dd_oe[PE_RX] = 1'b1;
      dd_ov[PE_RX] = 1'b0;
      pu_oe[PE_TX] = 1'b1;
      pu_ov[PE_TX] = 1'b0;
      dd_oe[PE_TX] = 1'b1;
      dd_ov[PE_TX] = 1'b1;
      pv_oe[PE_TX] = 1'b1;
      pv_ov[PE_TX] = PROG_DATA_OUT;
    end
    // Sync clock value override; direction stays with the port bit.
    pv_oe[PE_XCLK] = SERIAL0_SYNC_SELECT;
    pv_ov[PE_XCLK] = SERIAL0_CLOCK_OUT;
    pv_oe[PE_CMP_A] = TIMER3_COMPARE_A_EN;
    pv_ov[PE_CMP_A] = TIMER3_COMPARE_A_OUT;
    pv_oe[PE_CMP_B] = TIMER3_COMPARE_B_EN;
    pv_ov[PE_CMP_B] = TIMER3_COMPARE_B_OUT;
    pv_oe[PE_CMP_C] = TIMER3_COMPARE_C_EN;
    pv_ov[PE_CMP_C] = TIMER3_COMPARE_C_OUT;
    die_oe[PE_INT_BASE +: 4] = EXT_INT_ENABLE;
    die_ov[PE_INT_BASE +: 4] = 4'hF;
    // Legacy port F input only but for test port TDO; no other override on F3..F0.
    if (LEGACY_MODE) begin
      dd_oe[PORT_F_BASE +: PORT_WIDTH] = 8'hFF;
      dd_ov[PORT_F_BASE +: PORT_WIDTH] = 8'h00;
    end
    if (TEST_PORT_ENABLE) begin
      pu_oe[PORT_F_BASE + PF_TCK +: 4]  = 4'hF;
      dd_oe[PORT_F_BASE + PF_TCK +: 4]  = 4'hF;
      dd_ov[PORT_F_BASE + PF_TCK +: 4]  = 4'h0;
      die_oe[PORT_F_BASE + PF_TCK +: 4] = 4'hF;
      die_ov[PORT_F_BASE + PF_TCK +: 4] = 4'h0;
      pu_ov[PORT_F_BASE + PF_TDI] = 1'b1;
      pu_ov[PORT_F_BASE + PF_TMS] = 1'b1;
      pu_ov[PORT_F_BASE + PF_TCK] = 1'b1;
      dd_ov[PORT_F_BASE + PF_TDO] = TAP_SHIFT_INSTR | TAP_SHIFT_DATA;
      pv_oe[PORT_F_BASE + PF_TDO] = 1'b1;
      pv_ov[PORT_F_BASE + PF_TDO] = TAP_TDO_DATA;
    end
    // Legacy port G has no general I/O.
    if (LEGACY_MODE) begin
      pu_oe[PORT_G_BASE +: PORT_G_WIDTH] = 5'h1F;
      pu_ov[PORT_G_BASE +: PORT_G_WIDTH] = 5'h00;
      dd_oe[PORT_G_BASE +: PORT_G_WIDTH] = 5'h1F;
      dd_ov[PORT_G_BASE +: PORT_G_WIDTH] = 5'h00;
      pv_oe[PORT_G_BASE +: PORT_G_WIDTH] = 5'h1F;
      pv_ov[PORT_G_BASE +: PORT_G_WIDTH] = 5'h00;
    end
    if (TIMER0_ASYNC_SELECT) begin
      pu_oe[PORT_G_BASE + PG_OSC_OUT +: 2]  = 2'h3;
      pu_ov[PORT_G_BASE + PG_OSC_OUT +: 2]  = 2'h0;
      dd_oe[PORT_G_BASE + PG_OSC_OUT +: 2]  = 2'h3;
      dd_ov[PORT_G_BASE + PG_OSC_OUT +: 2]  = 2'h0;
      die_oe[PORT_G_BASE + PG_OSC_OUT +: 2] = 2'h3;
      die_ov[PORT_G_BASE + PG_OSC_OUT +: 2] = 2'h0;
    end
    if (EXT_MEMORY_ENABLE) begin
      pu_oe[PORT_G_BASE +: 3] = 3'h7;
      pu_ov[PORT_G_BASE +: 3] = 3'h0;
      dd_oe[PORT_G_BASE +: 3] = 3'h7;
      dd_ov[PORT_G_BASE +: 3] = 3'h7;
      pv_oe[PORT_G_BASE +: 3] = 3'h7;
      pv_ov[PORT_G_BASE + PG_LATCH]   = XMEM_ADDR_LATCH;
      pv_ov[PORT_G_BASE + PG_RSTROBE] = XMEM_READ_STROBE;
      pv_ov[PORT_G_BASE + PG_WSTROBE] = XMEM_WRITE_STROBE;
    end
  end

  // One override cell per pad.
  for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
    peao_pin_cell u_cell (
      .port_out                  (port_out_all[i]),
      .port_dir                  (port_dir_all[i]),
      .global_pullup_disable     (global_pullup_disable),
      .pullup_override_en        (pu_oe[i]),
      .pullup_override_val       (pu_ov[i]),
      .direction_override_en     (dd_oe[i]),
      .direction_override_val    (dd_ov[i]),
      .port_value_override_en    (pv_oe[i]),
      .port_value_override_val   (pv_ov[i]),
      .input_enable_override_en  (die_oe[i]),
      .input_enable_override_val (die_ov[i]),
      .pad_out                   (PAD_OUT[i]),
      .pad_oe                    (PAD_OE[i]),
      .pad_pullup                (PAD_PULLUP[i]),
      .pad_in_en                 (PAD_IN_EN[i])
    );
  end

  // Synchronised pad gated by its input enable.
  assign pin_state_nxt = pad_s2_r & PAD_IN_EN;

  // Pad synchroniser and gated pin state.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      pad_s1_r    <= PIN_RESET;
      pad_s2_r    <= PIN_RESET;
      pin_state_r <= PIN_RESET;
    end else begin
      pad_s1_r    <= PAD_IN;
      pad_s2_r    <= pad_s1_r;
      pin_state_r <= pin_state_nxt;
    end
  end

  // Peripheral inputs from the gated pin state.
  always_comb begin
    SERIAL0_RX_DATA     = pin_state_r[PE_RX];
    PROG_DATA_IN        = pin_state_r[PE_RX];
    SERIAL0_CLOCK_IN    = pin_state_r[PE_XCLK] & SERIAL0_SYNC_SELECT & ~port_e_dir_r[PE_XCLK];
    TIMER3_CAPTURE_IN   = pin_state_r[PE_CAPTURE];
    TIMER3_EXT_CLOCK_IN = pin_state_r[PE_T3_CLK];
    EXT_INT_IN          = pin_state_r[PE_INT_BASE +: 4];
    // Test inputs bypass the disabled digital input.
    TAP_TDI = pad_s2_r[PORT_F_BASE + PF_TDI] & TEST_PORT_ENABLE;
    TAP_TMS = pad_s2_r[PORT_F_BASE + PF_TMS] & TEST_PORT_ENABLE;
    TAP_TCK = pad_s2_r[PORT_F_BASE + PF_TCK] & TEST_PORT_ENABLE;
  end

  // APB decode; the slave never inserts wait states.
  assign apb_write = PSEL & PENABLE & PWRITE;
  assign apb_setup = PSEL & ~PENABLE;
  assign PREADY    = 1'b1;
  assign PRDATA    = rdata_r;
  assign PSLVERR   = PSEL & PENABLE & ~addr_hit;

  always_comb begin
    unique case (PADDR)
      OFS_PORT_E_OUT, OFS_PORT_E_DIR, OFS_PORT_F_OUT, OFS_PORT_F_DIR,
      OFS_PORT_G_OUT, OFS_PORT_G_DIR, OFS_CTRL,
      OFS_PIN_E, OFS_PIN_F, OFS_PIN_G: addr_hit = 1'b1;
      default:                         addr_hit = 1'b0;
    endcase
  end

  // Register writes at the access edge; read data captured in the setup cycle.
  always_comb begin
    port_e_out_nxt = port_e_out_r;
    port_e_dir_nxt = port_e_dir_r;
    port_f_out_nxt = port_f_out_r;
    port_f_dir_nxt = port_f_dir_r;
    port_g_out_nxt = port_g_out_r;
    port_g_dir_nxt = port_g_dir_r;
    ctrl_nxt       = ctrl_r;
    rdata_nxt      = rdata_r;
    if (apb_write) begin
      unique case (PADDR)
        OFS_PORT_E_OUT: port_e_out_nxt = PWDATA[7:0];
        OFS_PORT_E_DIR: port_e_dir_nxt = PWDATA[7:0];
        OFS_PORT_F_OUT: port_f_out_nxt = PWDATA[7:0];
        OFS_PORT_F_DIR: port_f_dir_nxt = PWDATA[7:0];
        OFS_PORT_G_OUT: port_g_out_nxt = PWDATA[4:0];
        OFS_PORT_G_DIR: port_g_dir_nxt = PWDATA[4:0];
        OFS_CTRL:       ctrl_nxt       = PWDATA[CTRL_PULLUP_DISABLE_BIT +: 1];
        default:        ;
      endcase
    end
    if (apb_setup) begin
      unique case (PADDR)
        OFS_PORT_E_OUT: rdata_nxt = 32'(port_e_out_r);
        OFS_PORT_E_DIR: rdata_nxt = 32'(port_e_dir_r);
        OFS_PORT_F_OUT: rdata_nxt = 32'(port_f_out_r);
        OFS_PORT_F_DIR: rdata_nxt = 32'(port_f_dir_r);
        OFS_PORT_G_OUT: rdata_nxt = 32'(port_g_out_r);
        OFS_PORT_G_DIR: rdata_nxt = 32'(port_g_dir_r);
        OFS_CTRL:       rdata_nxt = 32'(ctrl_r);
        OFS_PIN_E:      rdata_nxt = 32'(pin_state_r[PORT_E_BASE +: PORT_WIDTH]);
        OFS_PIN_F:      rdata_nxt = 32'(pin_state_r[PORT_F_BASE +: PORT_WIDTH]);
        OFS_PIN_G:      rdata_nxt = 32'(pin_state_r[PORT_G_BASE +: PORT_G_WIDTH]);
        default:        rdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Register file flip-flops.
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      port_e_out_r <= PORT_RESET;
      port_e_dir_r <= PORT_RESET;
      port_f_out_r <= PORT_RESET;
      port_f_dir_r <= PORT_RESET;
      port_g_out_r <= PORT_G_RESET;
      port_g_dir_r <= PORT_G_RESET;
      ctrl_r       <= CTRL_RESET;
      rdata_r      <= 32'h00000000;
    end else begin
      port_e_out_r <= port_e_out_nxt;
      port_e_dir_r <= port_e_dir_nxt;
      port_f_out_r <= port_f_out_nxt;
      port_f_dir_r <= port_f_dir_nxt;
      port_g_out_r <= port_g_out_nxt;
      port_g_dir_r <= port_g_dir_nxt;
      ctrl_r       <= ctrl_nxt;
      rdata_r      <= rdata_nxt;
    end
  end

endmodule : peao_top
